// ### logic/ldoc_pkg.sv
// constants, field layout and types for the regulator channel control registers
// Functional notes
// R1: undervoltage action bits 15:14: ignore, shut regulator, or device reset on 10.
// R2: every undervoltage event raises the interrupt, whatever action is selected.
// R3: source bits 12:11 pick none, control 1, control 2 or either as trigger.
// R4: bit 10 picks ON (0) or SLEEP (1) voltage code under hardware control.
// R5: mode bits 9:8: low power on 00/10, output off on 01, ON mode on 11.
// R6: bit 7 floats (1) or discharges (0) disabled output; bit 6 selects switch mode.
// R7: ON slot 000, the default, leaves the regulator off during start-up.
// R8: ON slot 001 to 101 enables the regulator in start-up timeslots one to five.
// R9: ON slot 110 and 111 hand enable to hardware enable input 1 or 2.
// R10: ON register bit 8 picks normal (0) or low power (1) in the ON state.
// R11: voltage code steps 50mV from 1.00V to 1.60V, then 100mV to 3.50V.
// R12: SLEEP slot 000, 110, 111 keep it on, moving to sleep in slot 5, 3, 1.
// R13: SLEEP slot 001 to 101 disable it in sleep timeslots five down to one.
// R14: with a hardware enable input, codes 001 to 101 pick the sleep-entry timeslot.
// R15: SLEEP register bit 8 picks normal (0) or low power (1, default) when asleep.
// R16: channel 7 sleep register holds its voltage code in bits 4:0, reset zero.
// R17: channel 7 sleep register also holds slot bits 15:13 and mode bit 8.
// R18: unassigned register bits read as zero and ignore writes.
package ldoc_pkg;
    localparam logic [15:0] IDX_REG7_SLEEP  = 16'h407c;
    localparam logic [15:0] IDX_REG8_CTRL   = 16'h407d;
    localparam logic [15:0] IDX_REG8_ON     = 16'h407e;
    localparam logic [15:0] IDX_REG8_SLEEP  = 16'h407f;
    localparam logic [15:0] IDX_IRQ_STATUS  = 16'h4090;
    localparam logic [15:0] IDX_IRQ_MASK    = 16'h4091;
    localparam logic [31:0] ADDR_REG7_SLEEP = {14'h0, IDX_REG7_SLEEP, 2'h0};
    localparam logic [31:0] ADDR_REG8_CTRL  = {14'h0, IDX_REG8_CTRL, 2'h0};
    localparam logic [31:0] ADDR_REG8_ON    = {14'h0, IDX_REG8_ON, 2'h0};
    localparam logic [31:0] ADDR_REG8_SLEEP = {14'h0, IDX_REG8_SLEEP, 2'h0};
    localparam logic [31:0] ADDR_IRQ_STATUS = {14'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] ADDR_IRQ_MASK   = {14'h0, IDX_IRQ_MASK, 2'h0};

    localparam int UVACT_LSB  = 14;
    localparam int HWSRC_LSB  = 11;
    localparam int HWVSEL_BIT = 10;
    localparam int HWMODE_LSB = 8;
    localparam int FLOAT_BIT  = 7;
    localparam int SWITCH_BIT = 6;
    localparam int SLOT_LSB   = 13;
    localparam int OPMODE_BIT = 8;
    localparam int VCODE_LSB  = 0;

    localparam logic [15:0] MASK_CTRL   = 16'hdfc0;
    localparam logic [15:0] MASK_SLOTS  = 16'he11f;
    localparam logic [15:0] RST_CTRL    = 16'h0200;
    localparam logic [15:0] RST_ON      = 16'h0000;
    localparam logic [15:0] RST_SLEEP   = 16'h0100;

    localparam logic [1:0] UV_SHUTDOWN  = 2'h1;
    localparam logic [1:0] UV_DEVRESET  = 2'h2;
    localparam logic [1:0] HWSRC_CTL1   = 2'h1;
    localparam logic [1:0] HWSRC_CTL2   = 2'h2;
    localparam logic [1:0] HWSRC_EITHER = 2'h3;
    localparam logic [1:0] HWMODE_OFF   = 2'h1;
    localparam logic [1:0] HWMODE_ONSET = 2'h3;
    localparam logic [2:0] SLOT_NONE    = 3'h0;
    localparam logic [2:0] SLOT_LAST    = 3'h5;
    localparam logic [2:0] SLOT_HWEN1   = 3'h6;
    localparam logic [2:0] SLOT_HWEN2   = 3'h7;
    localparam logic [2:0] SLOT_MID     = 3'h3;
    localparam logic [2:0] SLOT_FIRST   = 3'h1;
    localparam logic [2:0] SLOT_MIRROR  = 3'h6;

    localparam logic [4:0]  VC_FINE_LAST  = 5'h0c;
    localparam logic [4:0]  VC_KNEE       = 5'h0d;
    localparam logic [11:0] MV_BASE       = 12'h3e8;
    localparam logic [11:0] MV_STEP_FINE  = 12'h032;
    localparam logic [11:0] MV_KNEE       = 12'h6a4;
    localparam logic [11:0] MV_STEP_COARSE = 12'h064;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_ON    = 3'b010,
        ST_SLEEP = 3'b100
    } ldoc_state_t;
endpackage : ldoc_pkg

// ### logic/ldoc_regs.sv
// register bank and enable/voltage/mode control for regulator channel 8
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module ldoc_regs
    import ldoc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        uvDetect,
    input  wire logic        hwCtl1,
    input  wire logic        hwCtl2,
    input  wire logic        hwEnable1,
    input  wire logic        hwEnable2,
    input  wire logic        seqStartup,
    input  wire logic        seqSleep,
    input  wire logic [2:0]  seqSlot,
    output logic             ch8Enable,
    output logic [4:0]       ch8VoltageCode,
    output logic [11:0]      ch8MilliVolts,
    output logic             ch8LowPower,
    output logic             ch8OutputFloat,
    output logic             ch8SwitchMode,
    output logic             deviceResetReq,
    output logic [4:0]       ch7SleepVoltageCode,
    output logic [2:0]       ch7SleepTimeslot,
    output logic             ch7SleepOpMode,
    output logic             irq
);
    typedef struct packed {
        logic [15:0] reg7Sleep;
        logic [15:0] reg8Ctrl;
        logic [15:0] reg8On;
        logic [15:0] reg8Sleep;
        logic        irqStatus;
        logic        irqMask;
        logic        awHave;
        logic [31:0] awAddr;
        logic        wHave;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic        uvPrev;
        ldoc_state_t regState;
        logic        enable;
        logic        lowPower;
        logic        devReset;
        logic [4:0]  vcode;
        logic [11:0] mv;
    } ldoc_core_t;

    localparam ldoc_core_t CORE_RST = '{
        reg7Sleep: RST_SLEEP, reg8Ctrl: RST_CTRL, reg8On: RST_ON, reg8Sleep: RST_SLEEP,
        irqStatus: 1'b0, irqMask: 1'b0, awHave: 1'b0, awAddr: 32'h0, wHave: 1'b0,
        wData: 32'h0, wStrb: 4'h0, bValid: 1'b0, bResp: RESP_OKAY, rValid: 1'b0,
        rData: 32'h0, rResp: RESP_OKAY, sync1: 5'h0, sync2: 5'h0, uvPrev: 1'b0,
        regState: ST_OFF, enable: 1'b0, lowPower: 1'b0, devReset: 1'b0,
        vcode: 5'h0, mv: MV_BASE};

    ldoc_core_t cur;
    ldoc_core_t next_cur;

    // byte lanes 0 and 1 only; anything outside the mask stays zero
    function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb,
                                               input logic [15:0] mask);
        logic [15:0] merged;
        merged[7:0]  = strb[0] ? data[7:0] : old[7:0];
        merged[15:8] = strb[1] ? data[15:8] : old[15:8];
        return merged & mask; // see R18
    endfunction : mergeWrite

    function automatic logic [11:0] codeToMv(input logic [4:0] code);
        logic [11:0] wide;
        wide = {7'h0, code};
        if (code <= VC_FINE_LAST) begin
            return 12'(MV_BASE + wide * MV_STEP_FINE); // see R11
        end
        return 12'(MV_KNEE + (wide - {7'h0, VC_KNEE}) * MV_STEP_COARSE); // see R11
    endfunction : codeToMv

    function automatic logic [2:0] sleepSlotOf(input logic [2:0] code);
        case (code)
            SLOT_NONE:  return SLOT_LAST;
            SLOT_HWEN1: return SLOT_MID;
            SLOT_HWEN2: return SLOT_FIRST;
            default:    return 3'(SLOT_MIRROR - code);
        endcase
    endfunction : sleepSlotOf

    logic        uvEdge;
    logic [1:0]  uvAction;
    logic [2:0]  onSlot;
    logic [2:0]  sleepSlot;
    logic [2:0]  sleepTarget;
    logic        hwEnMode;
    logic        hwEnLevel;
    logic        hwCtlActive;
    logic        sleepDisables;
    logic        uvShut;
    logic        startHit;
    logic        sleepHit;
    logic        inSleep;
    logic        useSleepV;
    logic [1:0]  hwMode;
    logic [4:0]  vcodeSel;
    logic        awTake;
    logic        wTake;
    logic        arTake;
    logic        doWrite;
    logic [31:0] rdValue;
    logic        rdHit;

    assign awready = !cur.awHave;
    assign wready  = !cur.wHave;
    assign arready = !cur.rValid;
    assign awTake  = awvalid && awready;
    assign wTake   = wvalid && wready;
    assign arTake  = arvalid && arready;
    assign doWrite = cur.awHave && cur.wHave && !cur.bValid;

    assign uvEdge    = cur.sync2[0] && !cur.uvPrev;
    assign uvAction  = cur.reg8Ctrl[UVACT_LSB +: 2];
    assign hwMode    = cur.reg8Ctrl[HWMODE_LSB +: 2];
    assign onSlot    = cur.reg8On[SLOT_LSB +: 3];
    assign sleepSlot = cur.reg8Sleep[SLOT_LSB +: 3];
    assign uvShut    = uvEdge && (uvAction == UV_SHUTDOWN);
    assign inSleep   = (cur.regState == ST_SLEEP);

    always_comb begin
        rdValue = 32'h0;
        rdHit   = 1'b1;
        case (araddr)
            ADDR_REG7_SLEEP: rdValue = {16'h0, cur.reg7Sleep};
            ADDR_REG8_CTRL:  rdValue = {16'h0, cur.reg8Ctrl};
            ADDR_REG8_ON:    rdValue = {16'h0, cur.reg8On};
            ADDR_REG8_SLEEP: rdValue = {16'h0, cur.reg8Sleep};
            ADDR_IRQ_STATUS: rdValue = {31'h0, cur.irqStatus};
            ADDR_IRQ_MASK:   rdValue = {31'h0, cur.irqMask};
            default:         rdHit   = 1'b0;
        endcase
    end

    always_comb begin
        hwEnMode  = (onSlot == SLOT_HWEN1) || (onSlot == SLOT_HWEN2); // see R9
        hwEnLevel = (onSlot == SLOT_HWEN1) ? cur.sync2[3] : cur.sync2[4]; // see R9
        case (cur.reg8Ctrl[HWSRC_LSB +: 2])
            HWSRC_CTL1:   hwCtlActive = cur.sync2[1]; // see R3
            HWSRC_CTL2:   hwCtlActive = cur.sync2[2]; // see R3
            HWSRC_EITHER: hwCtlActive = cur.sync2[1] || cur.sync2[2]; // see R3
            default:      hwCtlActive = 1'b0;
        endcase
        sleepTarget   = sleepSlotOf(sleepSlot); // see R12 R13
        // in its sleep slot a regulator on a hardware enable only ever sleeps, never drops out
        sleepDisables = !hwEnMode && (sleepSlot != SLOT_NONE) && (sleepSlot <= SLOT_LAST); // see R14
        startHit = seqStartup && (onSlot != SLOT_NONE) && (onSlot <= SLOT_LAST)
                   && (seqSlot == onSlot); // see R7 R8
        sleepHit = seqSleep && (seqSlot == sleepTarget);
        useSleepV = hwCtlActive ? cur.reg8Ctrl[HWVSEL_BIT] : inSleep; // see R4
        vcodeSel  = useSleepV ? cur.reg8Sleep[VCODE_LSB +: 5] : cur.reg8On[VCODE_LSB +: 5];
    end

    always_comb begin
        next_cur = cur;
        next_cur.sync1  = {hwEnable2, hwEnable1, hwCtl2, hwCtl1, uvDetect};
        next_cur.sync2  = cur.sync1;
        next_cur.uvPrev = cur.sync2[0];

        if (awTake) begin
            next_cur.awHave = 1'b1;
            next_cur.awAddr = awaddr;
        end
        if (wTake) begin
            next_cur.wHave = 1'b1;
            next_cur.wData = wdata;
            next_cur.wStrb = wstrb;
        end
        if (cur.bValid && bready) begin
            next_cur.bValid = 1'b0;
        end
        if (doWrite) begin
            next_cur.awHave = 1'b0;
            next_cur.wHave  = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp  = RESP_OKAY;
            case (cur.awAddr)
                ADDR_REG7_SLEEP: next_cur.reg7Sleep =
                    mergeWrite(cur.reg7Sleep, cur.wData, cur.wStrb, MASK_SLOTS); // see R16 R17
                ADDR_REG8_CTRL:  next_cur.reg8Ctrl =
                    mergeWrite(cur.reg8Ctrl, cur.wData, cur.wStrb, MASK_CTRL);
                ADDR_REG8_ON:    next_cur.reg8On =
                    mergeWrite(cur.reg8On, cur.wData, cur.wStrb, MASK_SLOTS);
                ADDR_REG8_SLEEP: next_cur.reg8Sleep =
                    mergeWrite(cur.reg8Sleep, cur.wData, cur.wStrb, MASK_SLOTS);
                ADDR_IRQ_STATUS: begin
                    if (cur.wStrb[0] && cur.wData[0]) begin
                        next_cur.irqStatus = 1'b0;
                    end
                end
                ADDR_IRQ_MASK: begin
                    if (cur.wStrb[0]) begin
                        next_cur.irqMask = cur.wData[0];
                    end
                end
                default: next_cur.bResp = RESP_SLVERR;
            endcase
        end
        // placed after the clear so a same-cycle event is never lost
        if (uvEdge) begin
            next_cur.irqStatus = 1'b1; // see R2
        end

        if (cur.rValid && rready) begin
            next_cur.rValid = 1'b0;
        end
        if (arTake) begin
            next_cur.rValid = 1'b1;
            next_cur.rData  = rdValue;
            next_cur.rResp  = rdHit ? RESP_OKAY : RESP_SLVERR;
        end

        case (cur.regState)
            ST_OFF: begin
                if (hwEnMode ? hwEnLevel : startHit) begin
                    next_cur.regState = ST_ON; // see R8 R9
                end
            end
            ST_ON: begin
                if (hwEnMode && !hwEnLevel) begin
                    next_cur.regState = ST_OFF;
                end else if (sleepHit) begin
                    next_cur.regState = sleepDisables ? ST_OFF : ST_SLEEP; // see R12 R13 R14
                end
            end
            ST_SLEEP: begin
                if (hwEnMode && !hwEnLevel) begin
                    next_cur.regState = ST_OFF;
                end else if (seqStartup && (hwEnMode || seqSlot == onSlot)) begin
                    next_cur.regState = ST_ON;
                end
            end
            default: next_cur.regState = ST_OFF;
        endcase
        if (uvShut) begin
            next_cur.regState = ST_OFF; // see R1
        end
        // reserved action code 11 is treated as ignore
        next_cur.devReset = uvEdge && (uvAction == UV_DEVRESET); // see R1

        next_cur.enable = (cur.regState != ST_OFF) && !(hwCtlActive && hwMode == HWMODE_OFF); // see R5
        if (hwCtlActive) begin
            next_cur.lowPower = (hwMode == HWMODE_ONSET) ? cur.reg8On[OPMODE_BIT] : 1'b1; // see R5
        end else begin
            next_cur.lowPower = inSleep ? cur.reg8Sleep[OPMODE_BIT] : cur.reg8On[OPMODE_BIT]; // see R10 R15
        end
        next_cur.vcode = vcodeSel;
        next_cur.mv    = codeToMv(vcodeSel); // see R11
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= CORE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign bvalid              = cur.bValid;
    assign bresp               = cur.bResp;
    assign rvalid              = cur.rValid;
    assign rdata               = cur.rData;
    assign rresp               = cur.rResp;
    assign ch8Enable           = cur.enable;
    assign ch8VoltageCode      = cur.vcode;
    assign ch8MilliVolts       = cur.mv;
    assign ch8LowPower         = cur.lowPower;
    assign ch8OutputFloat      = cur.reg8Ctrl[FLOAT_BIT];  // see R6
    assign ch8SwitchMode       = cur.reg8Ctrl[SWITCH_BIT]; // see R6
    assign deviceResetReq      = cur.devReset;
    assign ch7SleepVoltageCode = cur.reg7Sleep[VCODE_LSB +: 5];
    assign ch7SleepTimeslot    = cur.reg7Sleep[SLOT_LSB +: 3];
    assign ch7SleepOpMode      = cur.reg7Sleep[OPMODE_BIT];
    assign irq                 = cur.irqStatus && cur.irqMask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence uvEvent;
        uvEdge;
    endsequence
    sequence resetPulse;
        deviceResetReq ##1 !deviceResetReq;
    endsequence
    sequence goneOff;
        (cur.regState == ST_OFF) ##1 !ch8Enable;
    endsequence

    AST_UV_IRQ: assert property (uvEvent |=> cur.irqStatus) // see R2
        else $error("undervoltage did not set interrupt status");
    AST_UV_DEVRESET: assert property ((uvEdge && uvAction == UV_DEVRESET) // see R1
        |=> resetPulse)
        else $error("device reset request not a one-cycle pulse");
    AST_UV_SHUTDOWN: assert property ((uvEdge && uvAction == UV_SHUTDOWN) // see R1
        |=> goneOff)
        else $error("regulator not shut down on undervoltage");
    AST_HW_OFF: assert property ((hwCtlActive && hwMode == HWMODE_OFF) |=> !ch8Enable) // see R5
        else $error("hardware control off mode left output enabled");
    AST_HW_VSEL: assert property ((hwCtlActive && cur.reg8Ctrl[HWVSEL_BIT]) // see R4
        |=> ch8VoltageCode == $past(cur.reg8Sleep[4:0]))
        else $error("hardware control did not use sleep voltage");
    AST_NO_SLOT: assert property ((cur.regState == ST_OFF && onSlot == SLOT_NONE) // see R7
        |=> cur.regState == ST_OFF)
        else $error("regulator enabled with no start-up slot");
    AST_START: assert property ( // see R8
        (cur.regState == ST_OFF && !hwEnMode && startHit && !uvShut)
        |=> cur.regState == ST_ON ##1 (ch8Enable || $past(hwCtlActive && hwMode == HWMODE_OFF)))
        else $error("regulator not enabled in its start-up slot");
    AST_HWEN: assert property ( // see R9
        (cur.regState == ST_OFF && hwEnMode && hwEnLevel && !uvShut)
        |=> cur.regState == ST_ON)
        else $error("hardware enable did not turn regulator on");
    AST_SLEEP_OFF: assert property ( // see R13
        (cur.regState == ST_ON && sleepHit && sleepDisables
        && !uvShut && !(hwEnMode && !hwEnLevel)) |=> cur.regState == ST_OFF)
        else $error("regulator not disabled in its sleep slot");
    AST_SLEEP_KEEP: assert property ( // see R12
        (cur.regState == ST_ON && sleepHit && !sleepDisables
        && !uvShut && !(hwEnMode && !hwEnLevel)) |=> cur.regState == ST_SLEEP)
        else $error("regulator did not enter sleep in its slot");
    AST_MV_TOP: assert property ((ch8VoltageCode == 5'h1f) |-> ch8MilliVolts == 12'hdac) // see R11
        else $error("top voltage code not 3500 mV");
    AST_MV_KNEE: assert property ((ch8VoltageCode == VC_KNEE) // see R11
        |-> ch8MilliVolts == MV_KNEE)
        else $error("knee voltage code wrong");
    AST_RESERVED: assert property ((cur.reg8Ctrl & ~MASK_CTRL) == 16'h0) // see R18
        else $error("reserved control bits not zero");

    // the state's own mode bit rules unless hardware control owns the output
    AST_ON_MODE: assert property ((cur.regState == ST_ON && !hwCtlActive) // see R10
        |=> ch8LowPower == $past(cur.reg8On[OPMODE_BIT]))
        else $error("on state ignored its mode bit");
    AST_SLEEP_MODE: assert property ((inSleep && !hwCtlActive) // see R15
        |=> ch8LowPower == $past(cur.reg8Sleep[OPMODE_BIT]))
        else $error("sleep state ignored its mode bit");
    AST_SLEEP_VOLT: assert property ((inSleep && !hwCtlActive) // see R12
        |=> ch8VoltageCode == $past(cur.reg8Sleep[VCODE_LSB +: 5]))
        else $error("sleep state ignored its voltage code");
    AST_HW_LOWPWR: assert property ((hwCtlActive && hwMode != HWMODE_ONSET) // see R5
        |=> ch8LowPower)
        else $error("hardware control did not force low power");
    AST_DEVRESET_CAUSE: assert property (deviceResetReq // see R1
        |-> $past(uvEdge && uvAction == UV_DEVRESET))
        else $error("device reset without its action code");
    AST_HWEN_DROP: assert property ((hwEnMode && !hwEnLevel) // see R9
        |=> cur.regState == ST_OFF)
        else $error("regulator kept on after hardware enable fell");
endmodule : ldoc_regs

// ### test/tb_top.sv
// self-checking bench for the channel 8 regulator control registers
`timescale 1ns/1ps
module tb_top
    import ldoc_pkg::*;
;
    logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, uvDetect, hwCtl1;
    logic        hwCtl2, hwEnable1, hwEnable2, seqStartup, seqSleep, awready, wready, bvalid;
    logic        arready, rvalid, ch8Enable, ch8LowPower, ch8OutputFloat, ch8SwitchMode;
    logic        deviceResetReq, ch7SleepOpMode, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [2:0]  seqSlot, ch7SleepTimeslot, on;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  ch8VoltageCode, ch7SleepVoltageCode;
    logic [11:0] ch8MilliVolts;
    int          failCount, comparisons, n, c, s, ent, prevOn, seen;
    logic [31:0] addrs [4] = '{ADDR_REG7_SLEEP, ADDR_REG8_CTRL, ADDR_REG8_ON, ADDR_REG8_SLEEP};
    logic [15:0] masks [4] = '{16'he11f, 16'hdfc0, 16'he11f, 16'he11f};
    logic [4:0]  vcs [8] = '{5'h00, 5'h01, 5'h0c, 5'h0d, 5'h0e, 5'h1e, 5'h1f, 5'h10};

    ldoc_regs ldoc_regs_inst (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .uvDetect, .hwCtl1, .hwCtl2, .hwEnable1, .hwEnable2,
        .seqStartup, .seqSleep, .seqSlot, .ch8Enable, .ch8VoltageCode, .ch8MilliVolts,
        .ch8LowPower, .ch8OutputFloat, .ch8SwitchMode, .deviceResetReq,
        .ch7SleepVoltageCode, .ch7SleepTimeslot, .ch7SleepOpMode, .irq);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finishTest

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chkVal

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        n++;
        if (n > 60) begin
            failCount++;
            $display("BAD %0t handshake timed out", $time);
            finishTest();
        end
    endtask : tick

    // bready stays high from the start, so the response is taken at the edge it is seen
    task automatic wrResp(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'h3;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            tick(1);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (awvalid === 1'b1 && !(awready === 1'b1) || wvalid === 1'b1 && !(wready === 1'b1));
        while (bvalid !== 1'b1) tick(1);
        r = bresp;
        bready <= 1'b0;
    endtask : wrResp

    task automatic rdResp(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do tick(1); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do tick(1); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rdResp

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wrResp(a, d, rsp);
        chkVal(rsp, RESP_OKAY);
    endtask : wr

    task automatic chkRd(input logic [31:0] a, input logic [31:0] exp);
        rdResp(a, rd, rsp);
        chkVal(rd, exp);
        chkVal(32'(rsp), 32'(RESP_OKAY));
    endtask : chkRd

    function automatic logic [11:0] mv(input logic [4:0] v);
        return (v <= 5'h0c) ? 12'h3e8 + 12'h032 * v : 12'h6a4 + 12'h064 * (v - 5'h0d);
    endfunction : mv

    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready, uvDetect, hwCtl1, hwCtl2} = '0;
        {hwEnable1, hwEnable2, seqStartup, seqSleep, seqSlot, wstrb} = '0;
        {awaddr, wdata, araddr} = '0;
        failCount = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        chkRd(ADDR_REG7_SLEEP, 32'h0100);
        chkRd(ADDR_REG8_CTRL, 32'h0200);
        chkRd(ADDR_REG8_ON, 32'h0000);
        chkRd(ADDR_REG8_SLEEP, 32'h0100);
        chkVal({ch8Enable, ch8MilliVolts}, {1'b0, 12'h3e8});
        for (c = 0; c < 4; c++) begin
            wr(addrs[c], 32'hffffffff);
            chkRd(addrs[c], {16'h0, masks[c]});
            if (c == 0) chkVal({ch7SleepVoltageCode, ch7SleepTimeslot, ch7SleepOpMode}, 9'h1ff);
            wr(addrs[c], 32'h0);
        end
        wrResp(32'h0100, 32'h1, rsp);
        chkVal(rsp, RESP_SLVERR);
        rdResp(32'h0100, rd, rsp);
        chkVal(rd, 32'h0);
        chkVal(32'(rsp), 32'(RESP_SLVERR));
        wr(ADDR_REG8_CTRL, 32'h00c0);
        tick(2);
        chkVal({ch8OutputFloat, ch8SwitchMode}, 2'h3);
        wr(ADDR_REG8_CTRL, 32'h0);
        prevOn = 0;
        for (c = 0; c < 8; c++) begin
            on = 3'(c % 5 + 1);
            wr(ADDR_REG8_ON, {16'h0, on, 8'h0, vcs[c]});
            wr(ADDR_REG8_SLEEP, {16'h0, 3'(c), 4'h0, 1'b1, 3'h0, 5'h1f});
            seqStartup <= 1'b1;
            for (s = 1; s < 6; s++) begin
                seqSlot <= 3'(s);
                n = 0;
                tick(3);
                chkVal(ch8Enable, prevOn != 0 || s >= on);
            end
            seqStartup <= 1'b0;
            chkVal({ch8VoltageCode, ch8MilliVolts}, {vcs[c], mv(vcs[c])});
            ent = (c == 0) ? 5 : (c == 6) ? 3 : (c == 7) ? 1 : 6 - c;
            seqSleep <= 1'b1;
            for (s = 1; s < 6; s++) begin
                seqSlot <= 3'(s);
                n = 0;
                tick(3);
                if (c >= 1 && c <= 5) chkVal(ch8Enable, s < ent);
                else chkVal({ch8Enable, ch8LowPower, ch8VoltageCode}, s >= ent ? 7'h7f : {2'h2, vcs[c]});
            end
            seqSleep <= 1'b0;
            prevOn = !(c >= 1 && c <= 5);
        end
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_REG8_CTRL, 32'h4000);
        uvDetect <= 1'b1;
        tick(6);
        chkVal({irq, ch8Enable}, 2'h2);
        uvDetect <= 1'b0;
        chkRd(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        tick(2);
        chkVal(irq, 1'b0);
        wr(ADDR_REG8_CTRL, 32'h8000);
        uvDetect <= 1'b1;
        seen = 0;
        repeat (10) begin
            @(posedge clk);
            seen += int'(deviceResetReq === 1'b1);
        end
        chkVal(seen, 1);
        uvDetect <= 1'b0;
        wr(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_REG8_CTRL, 32'h0);
        uvDetect <= 1'b1;
        tick(6);
        chkVal(irq, 1'b0);
        chkRd(ADDR_IRQ_STATUS, 32'h1);
        uvDetect <= 1'b0;
        wr(ADDR_REG8_ON, 32'hc002);
        hwEnable1 <= 1'b1;
        tick(6);
        chkVal(ch8Enable, 1'b1);
        wr(ADDR_REG8_SLEEP, 32'h611f);
        seqSleep <= 1'b1;
        seqSlot <= 3'h3;
        tick(3);
        chkVal({ch8Enable, ch8LowPower, ch8VoltageCode}, 7'h7f);
        seqSleep <= 1'b0;
        seqStartup <= 1'b1;
        seqSlot <= 3'h1;
        tick(3);
        seqStartup <= 1'b0;
        hwCtl2 <= 1'b1;
        // mode 01 turns the output off only while the chosen source is active
        for (c = 0; c < 4; c++) begin
            wr(ADDR_REG8_CTRL, (32'(c) << 11) | 32'h0100);
            tick(5);
            chkVal(ch8Enable, c < 2);
        end
        wr(ADDR_REG8_CTRL, 32'h1700);
        tick(2);
        chkVal({ch8Enable, ch8LowPower, ch8VoltageCode}, {2'h2, 5'h1f});
        wr(ADDR_REG8_ON, 32'hc102);
        tick(2);
        chkVal({ch8LowPower, ch8VoltageCode}, {1'b1, 5'h1f});
        hwEnable1 <= 1'b0;
        wr(ADDR_REG8_CTRL, 32'h0);
        tick(6);
        chkVal(ch8Enable, 1'b0);
        finishTest();
    end
endmodule : tb_top
